/* dhip_regs.vh */
// Constants for the converter host interface front end
`ifndef DHIP_REGS_VH
`define DHIP_REGS_VH
// Channel address and word layout
`define DHIP_ADDR_W        5
`define DHIP_DATA_W        14
`define DHIP_WORD_W        20
`define DHIP_OFS_BIT       19
`define DHIP_ADDR_MSB      18
`define DHIP_ADDR_LSB      14
// Levels read from undriven pins
`define DHIP_ADDR_DFLT     5'h1f
`define DHIP_SDIN_DFLT     1'h1
`define DHIP_CTL_DFLT      1'h0
// Serial clock limits, host side
`define DHIP_SCLK_MAX_HZ   14000000
`define DHIP_SCLK_SH_HZ    20000000
// Acquisition time and its length in cycles at 250 MHz
`define DHIP_CLK_MHZ       250
`define DHIP_ACQ_NS        1000
`define DHIP_ACQ_CYC       ((`DHIP_ACQ_NS * `DHIP_CLK_MHZ + 999) / 1000)
// Buffer shape
`define DHIP_FIFO_DEPTH    16
`define DHIP_FIFO_AW       4
`endif

/* dhip_top.v */
// Host interface front end: pin sampling, parallel and serial ports, buffer
`timescale 1ns/1ps
`include "dhip_regs.vh"

// ----------------------------------------------------------------
// Synchronous FIFO, flip-flop storage
// ----------------------------------------------------------------
module dhip_fifo #(
   parameter WIDTH = `DHIP_WORD_W,
   parameter DEPTH = `DHIP_FIFO_DEPTH,
   parameter AW    = `DHIP_FIFO_AW
) (
   input  wire             clock_i,
   input  wire             rst_b_i,
   input  wire [WIDTH-1:0] in_data_i,
   input  wire             in_valid_i,
   output wire             in_ready_o,
   output wire [WIDTH-1:0] out_data_o,
   output wire             out_valid_o,
   input  wire             out_ready_i
);
   reg [WIDTH-1:0] mem_r [0:DEPTH-1];
   reg [AW-1:0]    wr_ptr_r;
   reg [AW-1:0]    rd_ptr_r;
   reg [AW:0]      count_r;
   wire            push;
   wire            pop;

   // Handshakes on both sides
   assign in_ready_o  = (count_r != DEPTH[AW:0]);
   assign out_valid_o = (count_r != {(AW+1){1'b0}});
   assign out_data_o  = mem_r[rd_ptr_r];
   assign push        = in_valid_i & in_ready_o;
   assign pop         = out_valid_o & out_ready_i;

   // Storage write
   always @(posedge clock_i) begin
      if (push) begin
         mem_r[wr_ptr_r] <= in_data_i;
      end
   end

   // Pointers and fill level
   always @(posedge clock_i) begin
      if (!rst_b_i) begin
         wr_ptr_r <= {AW{1'b0}};
         rd_ptr_r <= {AW{1'b0}};
         count_r  <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wr_ptr_r <= wr_ptr_r + 1'b1;
         end
         if (pop) begin
            rd_ptr_r <= rd_ptr_r + 1'b1;
         end
         if (push & ~pop) begin
            count_r <= count_r + 1'b1;
         end else if (pop & ~push) begin
            count_r <= count_r - 1'b1;
         end
      end
   end
endmodule

// ----------------------------------------------------------------
// Top: pin front end of the converter
// ----------------------------------------------------------------
module dhip_top #(
   parameter ACQ_CYC = `DHIP_ACQ_CYC,
   parameter DATA_W  = `DHIP_DATA_W
) (
   input  wire                    clock_i,
   input  wire                    rst_b_i,
   // Pins: value, plus far-end drive enable except on data, select and serial clock
   input  wire [`DHIP_ADDR_W-1:0] channel_address_pins_i,
   input  wire [`DHIP_ADDR_W-1:0] channel_address_drv_i,
   input  wire [DATA_W-1:0]       par_data_i,
   input  wire                    acquire_all_i,
   input  wire                    acquire_all_drv_i,
   input  wire                    sel_sync_b_i,
   input  wire                    wr_b_i,
   input  wire                    wr_b_drv_i,
   input  wire                    offset_sel_i,
   input  wire                    offset_sel_drv_i,
   input  wire                    interface_select_i,
   input  wire                    interface_select_drv_i,
   input  wire                    sclk_i,
   input  wire                    sdin_i,
   input  wire                    sdin_drv_i,
   // Readback source, same clock domain
   input  wire [DATA_W-1:0]       readback_data_i,
   // Pins driven by the device
   output reg                     dout_o,
   output reg                     dout_oe_o,
   output reg                     busy_o,
   // Core side
   output reg                     acquire_all_o,
   output reg                     serial_mode_o,
   output wire [`DHIP_WORD_W-1:0] word_o,
   output wire                    word_valid_o,
   input  wire                    word_ready_i,
   output reg                     overflow_o
);
   localparam CW = 16;
   // Acquisition states
   localparam ST_IDLE = 1'b0;
   localparam ST_ACQ  = 1'b1;

   // ----------------------------------------------------------------
   // Pin levels with pull defaults, then two-flop sync
   // ----------------------------------------------------------------
   wire [`DHIP_ADDR_W-1:0] addr_pin;
   wire [10:0]             pins_raw;
   reg  [10:0]             meta_r;
   reg  [10:0]             sync_r;
   reg  [DATA_W-1:0]       pdat_meta_r;
   reg  [DATA_W-1:0]       pdat_r;

   // Undriven address bits default high
   genvar gi;
   generate
      for (gi = 0; gi < `DHIP_ADDR_W; gi = gi + 1) begin : g_addr
         assign addr_pin[gi] = channel_address_drv_i[gi] ?
                               channel_address_pins_i[gi] : 1'b1;
      end
   endgenerate

   assign pins_raw = {
      sdin_drv_i ? sdin_i : `DHIP_SDIN_DFLT,
      acquire_all_drv_i ? acquire_all_i : `DHIP_CTL_DFLT,
      wr_b_drv_i ? wr_b_i : `DHIP_CTL_DFLT,
      offset_sel_drv_i ? offset_sel_i : `DHIP_CTL_DFLT,
      interface_select_drv_i ? interface_select_i : `DHIP_CTL_DFLT,
      sel_sync_b_i, sclk_i, addr_pin[3:0]};

   // Sync stage, first flop read only by second
   always @(posedge clock_i) begin
      if (!rst_b_i) begin
         meta_r      <= 11'h52f;                 // Idle pin levels
         sync_r      <= 11'h52f;
         pdat_meta_r <= {DATA_W{1'b0}};
         pdat_r      <= {DATA_W{1'b0}};
      end else begin
         meta_r      <= pins_raw;
         sync_r      <= meta_r;
         pdat_meta_r <= par_data_i;
         pdat_r      <= pdat_meta_r;
      end
   end

   // Top address bit synchronised alone
   reg a4_meta_r;
   reg a4_r;
   always @(posedge clock_i) begin
      if (!rst_b_i) begin
         a4_meta_r <= 1'b1;
         a4_r      <= 1'b1;
      end else begin
         a4_meta_r <= addr_pin[4];
         a4_r      <= a4_meta_r;
      end
   end

   // Named synchronised levels
   wire [4:0] addr_s    = {a4_r, sync_r[3:0]};
   wire       sclk_s    = sync_r[4];
   wire       sel_b_s   = sync_r[5];
   wire       ser_s     = sync_r[6];
   wire       ofs_s     = sync_r[7];
   wire       wr_b_s    = sync_r[8];
   wire       acq_s     = sync_r[9];
   wire       sdin_s    = sync_r[10];

   // ----------------------------------------------------------------
   // Edge detection on synchronised levels
   // ----------------------------------------------------------------
   reg  sclk_d_r;
   reg  sel_d_r;
   reg  pacc_d_r;
   reg  acq_d_r;
   wire par_acc  = ~ser_s & ~sel_b_s & ~wr_b_s;
   wire pacc_rise = par_acc & ~pacc_d_r;
   wire sclk_fall = sclk_d_r & ~sclk_s;
   wire sclk_rise = ~sclk_d_r & sclk_s;
   wire in_frame  = ser_s & ~sel_b_s;
   wire frm_start = ser_s & sel_d_r & ~sel_b_s;
   wire frm_end   = ser_s & ~sel_d_r & sel_b_s;
   wire acq_rise  = ~ser_s & acq_s & ~acq_d_r;

   always @(posedge clock_i) begin
      if (!rst_b_i) begin
         sclk_d_r <= 1'b0;                       // Host idles clock low
         sel_d_r  <= 1'b1;
         pacc_d_r <= 1'b0;
         acq_d_r  <= 1'b0;
      end else begin
         sclk_d_r <= sclk_s;
         sel_d_r  <= sel_b_s;
         pacc_d_r <= par_acc;
         acq_d_r  <= acq_s;
      end
   end

   // ----------------------------------------------------------------
   // Serial receive and readback shift
   // ----------------------------------------------------------------
   reg [`DHIP_WORD_W-1:0] sr_in_r;
   reg [4:0]              bit_cnt_r;
   reg [DATA_W-1:0]       sr_out_r;

   always @(posedge clock_i) begin
      if (!rst_b_i) begin
         sr_in_r   <= {`DHIP_WORD_W{1'b0}};
         bit_cnt_r <= 5'h00;
         sr_out_r  <= {DATA_W{1'b0}};
         dout_o    <= 1'b0;
         dout_oe_o <= 1'b0;
      end else begin
         if (frm_start) begin
            bit_cnt_r <= 5'h00;
            sr_out_r  <= readback_data_i;
         end else if (in_frame & sclk_fall) begin
            sr_in_r   <= {sr_in_r[`DHIP_WORD_W-2:0], sdin_s};
            if (bit_cnt_r != 5'h1f) begin
               bit_cnt_r <= bit_cnt_r + 5'h01;
            end
         end else if (in_frame & sclk_rise) begin
            dout_o   <= sr_out_r[DATA_W-1];
            sr_out_r <= {sr_out_r[DATA_W-2:0], 1'b0};
         end
         dout_oe_o <= in_frame;
      end
   end

   // ----------------------------------------------------------------
   // Word capture into the buffer
   // ----------------------------------------------------------------
   wire                    ser_done = frm_end &
                           (bit_cnt_r == `DHIP_WORD_W);
   wire [`DHIP_WORD_W-1:0] par_word = {ofs_s, addr_s, pdat_r};
   wire [`DHIP_WORD_W-1:0] push_word = ser_done ? sr_in_r : par_word;
   wire                    push_v   = ser_done | pacc_rise;
   wire                    fifo_rdy;

   dhip_fifo #(
      .WIDTH (`DHIP_WORD_W),
      .DEPTH (`DHIP_FIFO_DEPTH),
      .AW    (`DHIP_FIFO_AW)
   ) u_fifo (
      .clock_i     (clock_i),
      .rst_b_i     (rst_b_i),
      .in_data_i   (push_word),
      .in_valid_i  (push_v),
      .in_ready_o  (fifo_rdy),
      .out_data_o  (word_o),
      .out_valid_o (word_valid_o),
      .out_ready_i (word_ready_i)
   );

   // Sticky flag when a word meets a full buffer
   always @(posedge clock_i) begin
      if (!rst_b_i) begin
         overflow_o <= 1'b0;
      end else if (push_v & ~fifo_rdy) begin
         overflow_o <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Acquire-all sequence and busy
   // ----------------------------------------------------------------
   reg          st_r;
   reg [CW-1:0] acq_cnt_r;

   always @(posedge clock_i) begin
      if (!rst_b_i) begin
         st_r          <= ST_IDLE;
         acq_cnt_r     <= {CW{1'b0}};
         busy_o        <= 1'b1;
         acquire_all_o <= 1'b0;
         serial_mode_o <= 1'b0;
      end else begin
         serial_mode_o <= ser_s;
         acquire_all_o <= 1'b0;
         case (st_r)
            ST_IDLE: begin
               if (acq_rise) begin
                  st_r          <= ST_ACQ;
                  acq_cnt_r     <= ACQ_CYC[CW-1:0] - 1'b1;
                  acquire_all_o <= 1'b1;
                  busy_o        <= 1'b0;
               end
            end
            ST_ACQ: begin
               if (acq_cnt_r == {CW{1'b0}}) begin
                  st_r   <= ST_IDLE;
                  busy_o <= 1'b1;
               end else begin
                  acq_cnt_r <= acq_cnt_r - 1'b1;
               end
            end
            default: begin
               st_r   <= ST_IDLE;
               busy_o <= 1'b1;
            end
         endcase
      end
   end
endmodule

/* dhip_top_asserts.sv */
// Checker of the converter host interface pin behaviour
`timescale 1ns/1ps
module dhip_top_asserts #(
   parameter ACQ_CYC = 8
) (
   input wire        clock_i,
   input wire        rst_b_i,
   input wire        acquire_all_i,
   input wire        acquire_all_drv_i,
   input wire        interface_select_i,
   input wire        interface_select_drv_i,
   input wire        sel_sync_b_i,
   input wire        sclk_i,
   input wire        word_ready_i,
   input wire        dout_o,
   input wire        dout_oe_o,
   input wire        busy_o,
   input wire        acquire_all_o,
   input wire        serial_mode_o,
   input wire [19:0] word_o,
   input wire        word_valid_o,
   input wire        overflow_o
);
   // ------------------------------------
   // Effective pin levels, busy-low count
   // ------------------------------------
   reg  [15:0] low_r;
   wire        isel = interface_select_i & interface_select_drv_i;
   wire        acq  = acquire_all_i & acquire_all_drv_i;
   always @(posedge clock_i) begin
      low_r <= busy_o ? 16'h0 : low_r + 16'h1;
   end
   default clocking @(posedge clock_i); endclocking
   default disable iff (!rst_b_i);
   reset_levels_a: assert property (disable iff (1'b0) !rst_b_i |=>
      busy_o && !dout_oe_o && !acquire_all_o && !word_valid_o && !overflow_o)
      else $error("outputs not at reset level");
   acq_start_a: assert property ($rose(acq) && busy_o && !serial_mode_o
      |-> ##3 acquire_all_o) else $error("acquire pulse late");
   acq_pulse_a: assert property (acquire_all_o |-> !busy_o
      ##1 !acquire_all_o) else $error("acquire pulse malformed");
   busy_len_a: assert property ($rose(busy_o) |-> low_r == ACQ_CYC)
      else $error("busy low length wrong");
   mode_follow_a: assert property ($stable(isel) [*5] |->
      serial_mode_o == isel) else $error("port choice not followed");
   frame_idle_a: assert property (sel_sync_b_i [*5] |-> !dout_oe_o)
      else $error("readback driven outside frame");
   readback_edge_a: assert property ($changed(dout_o) && $past(dout_oe_o)
      && dout_oe_o |-> sclk_i) else $error("readback moved on low clock");
   word_hold_a: assert property (word_valid_o && !word_ready_i |=>
      word_valid_o && $stable(word_o)) else $error("word not held");
   overflow_keep_a: assert property (overflow_o |=> overflow_o)
      else $error("overflow flag lost");
   cover property (acquire_all_o);
   cover property ($rose(overflow_o));
   cover property ($fell(dout_oe_o));
endmodule
bind dhip_top dhip_top_asserts #(.ACQ_CYC(ACQ_CYC)) dhip_top_asserts_inst (
   .clock_i, .rst_b_i, .acquire_all_i, .acquire_all_drv_i,
   .interface_select_i, .interface_select_drv_i, .sel_sync_b_i, .sclk_i,
   .word_ready_i, .dout_o, .dout_oe_o, .busy_o, .acquire_all_o,
   .serial_mode_o, .word_o, .word_valid_o, .overflow_o);

/* dhip_host_model.sv */
// Serial host model: frame sync, serial clock, data and readback capture
`timescale 1ns/1ps
module dhip_host_model (
   output reg  sclk_o,
   output reg  sdin_o,
   output reg  sdin_drv_o,
   output reg  sync_b_o,
   input  wire dout_i
);
   // Idle: clock still, data released to its pull-up
   initial begin
      sclk_o = 1'b0;
      sdin_o = 1'b0;
      sdin_drv_o = 1'b0;
      sync_b_o = 1'b1;
   end
   // One frame MSB first at 8 MHz; data moves on rise, held over fall
   task automatic frame(input logic [19:0] w, input int nb,
                        output logic [19:0] rb);
      rb = 20'h0;
      sync_b_o = 1'b0;
      #100;
      for (int i = 0; i < nb; i++) begin
         sclk_o = 1'b1;
         sdin_drv_o = 1'b1;
         sdin_o = w[19-i];
         #62.5;
         sclk_o = 1'b0;
         rb = {rb[18:0], dout_i};
         #62.5;
      end
      sdin_drv_o = 1'b0;
      sdin_o = ~sdin_o;
      #100;
      sync_b_o = 1'b1;
      #100;
   endtask
endmodule

/* tb_dac_host_interface_pins.sv */
// Random and corner-case bench of the host interface front end
`timescale 1ns/1ps
module tb_dac_host_interface_pins;
   localparam ACQ = 8;
   reg          clock_i = 1'b0;
   reg          rst_b_i = 1'b0;
   reg  [4:0]   addr = 5'h0, addr_drv = 5'h1f;
   reg  [13:0]  pdata = 14'h0, rbdata = 14'h0;
   reg          acq = 1'b0, acq_drv = 1'b1, cs_b = 1'b1, wr_b = 1'b1;
   reg          wr_drv = 1'b1, ofs = 1'b0, ofs_drv = 1'b1, isel = 1'b1;
   reg          isel_drv = 1'b0, ready = 1'b0;
   wire         sclk, sdin, sdin_drv, sync_b, dout, busy, acq_o, smode;
   wire         wvalid, ovf;
   wire [19:0]  word;
   int          n_fail = 0, check_count = 0, cyc = 0, pulses = 0;
   logic [19:0] exp_q[$];
   dhip_host_model dhip_host_model_inst (.sclk_o(sclk), .sdin_o(sdin),
      .sdin_drv_o(sdin_drv), .sync_b_o(sync_b), .dout_i(dout));
   dhip_top #(.ACQ_CYC(ACQ)) dhip_top_inst (.clock_i(clock_i),
      .rst_b_i(rst_b_i), .channel_address_pins_i(addr),
      .channel_address_drv_i(addr_drv), .par_data_i(pdata),
      .acquire_all_i(acq), .acquire_all_drv_i(acq_drv),
      .sel_sync_b_i(cs_b & sync_b), .wr_b_i(wr_b), .wr_b_drv_i(wr_drv),
      .offset_sel_i(ofs), .offset_sel_drv_i(ofs_drv),
      .interface_select_i(isel), .interface_select_drv_i(isel_drv),
      .sclk_i(sclk), .sdin_i(sdin), .sdin_drv_i(sdin_drv),
      .readback_data_i(rbdata), .dout_o(dout), .dout_oe_o(), .busy_o(busy),
      .acquire_all_o(acq_o), .serial_mode_o(smode), .word_o(word),
      .word_valid_o(wvalid), .word_ready_i(ready), .overflow_o(ovf));
   initial forever #2 clock_i = ~clock_i;
   // Cycle limit and acquire pulse count
   always @(posedge clock_i) begin
      cyc++;
      if (acq_o === 1'b1) pulses++;
      if (cyc == 30000) begin
         n_fail++;
         end_sim;
      end
   end
   task chk(input logic [19:0] got, input logic [19:0] exp);
      check_count++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD t=%0t got %h want %h", $time, got, exp);
      end
   endtask
   task end_sim;
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // Floating address bits read high, floating offset select reads low
   function automatic [19:0] expw(input [19:0] w, input [4:0] ad,
                                  input od);
      expw = {w[19] & od, w[18:14] | ~ad, w[13:0]};
   endfunction
   // Parallel write; strobe level follows whether it is driven
   task pw(input logic [19:0] w, input logic [4:0] ad, input logic od);
      @(negedge clock_i);
      {ofs, addr, pdata} = w;
      addr_drv = ad;
      ofs_drv = od;
      cs_b = 1'b0;
      wr_b = ~wr_drv;
      repeat (4) @(negedge clock_i);
      cs_b = 1'b1;
      wr_b = 1'b1;
      repeat (4) @(negedge clock_i);
   endtask
   // Pop one word after a random stall
   task pop(input logic [19:0] e);
      int k;
      k = 0;
      repeat ($urandom_range(0, 3)) @(negedge clock_i);
      while (wvalid !== 1'b1 && k < 200) begin
         @(negedge clock_i);
         k++;
      end
      chk(word, e);
      ready = 1'b1;
      @(negedge clock_i);
      ready = 1'b0;
   endtask
   initial begin
      logic [19:0] w, rb;
      int n;
      void'($urandom(86255));
      repeat (4) @(negedge clock_i);
      rst_b_i = 1'b1;
      // Fill past depth with the consumer stalled, then drain
      for (int i = 0; i < 17; i++) begin
         w = $urandom;
         wr_drv = (i != 3);
         pw(w, (i == 1) ? 5'h0 : 5'h1f, i[0]);
         exp_q.push_back(expw(w, (i == 1) ? 5'h0 : 5'h1f, i[0]));
      end
      wr_drv = 1'b1;
      chk(ovf, 20'h1);
      void'(exp_q.pop_back());
      while (exp_q.size() > 0) pop(exp_q.pop_front());
      // Strobe without select, select without strobe
      wr_b = 1'b0;
      repeat (8) @(negedge clock_i);
      wr_b = 1'b1;
      cs_b = 1'b0;
      repeat (8) @(negedge clock_i);
      cs_b = 1'b1;
      repeat (8) @(negedge clock_i);
      chk(wvalid, 20'h0);
      // Undriven acquire pin, then a real acquisition
      acq = 1'b1;
      acq_drv = 1'b0;
      repeat (10) @(negedge clock_i);
      acq_drv = 1'b1;
      n = 0;
      while (busy !== 1'b0 && n < 20) begin
         @(negedge clock_i);
         n++;
      end
      n = 0;
      while (busy === 1'b0 && n < 100) begin
         @(negedge clock_i);
         n++;
      end
      acq = 1'b0;
      chk(n, ACQ);
      chk(pulses, 20'h1);
      // Serial port: good frame, short frame, ignored strobe and acquire
      isel_drv = 1'b1;
      repeat (8) @(negedge clock_i);
      chk(smode, 20'h1);
      rbdata = $urandom;
      w = $urandom;
      dhip_host_model_inst.frame(w, 20, rb);
      chk(rb[19:6], rbdata);
      pop(w);
      dhip_host_model_inst.frame(w, 19, rb);
      pw(20'h5a5a5, 5'h1f, 1'b1);
      acq = 1'b1;
      repeat (20) @(negedge clock_i);
      chk(wvalid, 20'h0);
      chk(pulses, 20'h1);
      end_sim;
   end
endmodule
